/* File: inc/pwm_frontend_pkg.sv */
package pwm_frontend_pkg;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // Register indices; the byte address is four times the index.
  localparam logic [11:0] IDX_OV_LEVEL    = 12'h190;
  localparam logic [11:0] IDX_DESAT_CTRL  = 12'h191;
  localparam logic [11:0] IDX_CUR_OFFSET  = 12'h192;
  localparam logic [11:0] IDX_BLANKING    = 12'h193;
  localparam logic [11:0] IDX_SLOPE       = 12'h194;
  localparam logic [11:0] IDX_DEAD_TIME   = 12'h195;
  localparam logic [11:0] IDX_OFFSET_TRIM = 12'h196;
  localparam logic [11:0] IDX_BYPASS      = 12'h197;
  localparam logic [11:0] IDX_FLAG        = 12'h198;

  localparam logic [11:0] ADDR_OV_LEVEL    = IDX_OV_LEVEL << 2;
  localparam logic [11:0] ADDR_DESAT_CTRL  = IDX_DESAT_CTRL << 2;
  localparam logic [11:0] ADDR_CUR_OFFSET  = IDX_CUR_OFFSET << 2;
  localparam logic [11:0] ADDR_BLANKING    = IDX_BLANKING << 2;
  localparam logic [11:0] ADDR_SLOPE       = IDX_SLOPE << 2;
  localparam logic [11:0] ADDR_DEAD_TIME   = IDX_DEAD_TIME << 2;
  localparam logic [11:0] ADDR_OFFSET_TRIM = IDX_OFFSET_TRIM << 2;
  localparam logic [11:0] ADDR_BYPASS      = IDX_BYPASS << 2;
  localparam logic [11:0] ADDR_FLAG        = IDX_FLAG << 2;

  // Field layout.
  localparam int CUR_OFFSET_W   = 4;
  localparam int BLANK_W        = 2;
  localparam int SLOPE_RATE_W   = 6;
  localparam int SLOPE_BYP_BIT  = 6;
  localparam int DEAD_CODE_W    = 4;
  localparam int DEAD_P_LSB     = 4;
  localparam int DEAD_S_LSB     = 0;
  localparam int BYP_P_BIT      = 1;
  localparam int BYP_S_BIT      = 0;
  localparam int FLAG_BIT       = 0;

  // Reset values.
  localparam logic [7:0] RST_OV_LEVEL    = 8'h00;
  localparam logic [7:0] RST_DESAT_CTRL  = 8'h00;
  localparam logic [7:0] RST_CUR_OFFSET  = 8'h00;
  localparam logic [7:0] RST_BLANKING    = 8'h00;
  localparam logic [7:0] RST_SLOPE       = 8'h00;
  localparam logic [7:0] RST_DEAD_TIME   = 8'h00;
  localparam logic [7:0] RST_OFFSET_TRIM = 8'h00;
  localparam logic [7:0] RST_BYPASS      = 8'h00;

  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int LEB_NS_1      = 50;
  localparam int LEB_NS_2      = 100;
  localparam int LEB_NS_3      = 200;
  localparam int LEB_CYC_1     = (LEB_NS_1 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_CYC_2     = (LEB_NS_2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_CYC_3     = (LEB_NS_3 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LEB_CNT_W     = 6;
  localparam int DEAD_STEP_NS  = 16;
  localparam int DEAD_NS_W     = 9;

  typedef struct packed {
    logic input_select;
    logic watchdog_reset_enable;
    logic reserved;
    logic polarity_invert;
    logic output_enable;
    logic status;
    logic rise_irq_enable;
    logic fall_irq_enable;
  } desat_ctrl_type;

endpackage

/* File: tb/power_stage_model.sv */
`timescale 1ns/1ps
module power_stage_model #(
  parameter real SENSE_DLY_NS = 1.3
) (
  input  wire logic desat_level,
  input  wire logic trip_enable,
  input  wire logic primary_gate_drive,
  output logic      desat_comparator_raw,
  output logic      primary_current_trip
);
  // The comparator is not clocked, so its output moves between clock edges.
  assign #(SENSE_DLY_NS) desat_comparator_raw = desat_level;
  // Turn-on ringing keeps the sense comparator tripped while the switch is on.
  assign primary_current_trip = trip_enable && primary_gate_drive;
endmodule // power_stage_model

/* File: tb/pwm_frontend_config_bank_properties.sv */
`timescale 1ns/1ps
module pwm_frontend_config_bank_checker (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        watchdog_pulse,
  input wire logic        primary_pwm_request,
  input wire logic        secondary_pwm_request,
  input wire logic        primary_current_trip,
  input wire logic        pwm_watchdog_reset,
  input wire logic        desat_pwm_trip,
  input wire logic        desat_irq_flag,
  input wire logic        primary_current_trip_blanked,
  input wire logic        primary_gate_drive,
  input wire logic        secondary_gate_drive
);
  logic [7:0] ctl_r, dead_r, byp_r;
  int         pcnt_r, scnt_r;
  wire        wr_ok = psel && penable && pready && pwrite && pstrb[0];
  wire        clr   = wr_ok && paddr == pwm_frontend_pkg::ADDR_FLAG && pwdata[0];

  // Shadow copies of the controls, and how many edges each request has been high.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl_r  <= 8'h00;
      dead_r <= 8'h00;
      byp_r  <= 8'h00;
      pcnt_r <= 0;
      scnt_r <= 0;
    end else begin
      if (wr_ok && paddr == pwm_frontend_pkg::ADDR_DESAT_CTRL) ctl_r <= pwdata[7:0];
      if (wr_ok && paddr == pwm_frontend_pkg::ADDR_DEAD_TIME) dead_r <= pwdata[7:0];
      if (wr_ok && paddr == pwm_frontend_pkg::ADDR_BYPASS) byp_r <= pwdata[7:0];
      pcnt_r <= primary_pwm_request ? pcnt_r + 1 : 0;
      scnt_r <= secondary_pwm_request ? scnt_r + 1 : 0;
    end
  end

  function automatic int dly(input logic [3:0] c);
    return ((int'(c) + 1) * 16 + 4) / 5 + 1;
  endfunction

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence

  a_ready_setup: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_wdog_gate: assert property (pwm_watchdog_reset == $past(watchdog_pulse && ctl_r[6]))
    else $error("watchdog reset not gated by its enable");
  a_trip_gate: assert property (desat_pwm_trip |-> $past(ctl_r[3]))
    else $error("desat trip while output disabled");
  a_flag_edge_enable: assert property ($rose(desat_irq_flag) |-> $past(ctl_r[1] || ctl_r[0]))
    else $error("flag set with both edges disabled");
  a_flag_sticky: assert property (desat_irq_flag && !clr |=> desat_irq_flag)
    else $error("flag dropped without a clear");
  a_primary_dead: assert property ($rose(primary_gate_drive) |->
    (byp_r[1] ? pcnt_r <= 2 : pcnt_r == dly(dead_r[7:4])))
    else $error("primary turn-on delay wrong");
  a_secondary_dead: assert property ($rose(secondary_gate_drive) |->
    (byp_r[0] ? scnt_r <= 2 : scnt_r == dly(dead_r[3:0])))
    else $error("secondary turn-on delay wrong");
  a_drive_release: assert property (!primary_pwm_request |=> !primary_gate_drive)
    else $error("primary drive held without request");
  a_blank_cause: assert property (primary_current_trip_blanked |-> $past(primary_current_trip))
    else $error("blanked trip without a trip");
endmodule // pwm_frontend_config_bank_checker

bind pwm_frontend_config_bank pwm_frontend_config_bank_checker
  i_pwm_frontend_config_bank_checker (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .watchdog_pulse(watchdog_pulse), .primary_pwm_request(primary_pwm_request),
  .secondary_pwm_request(secondary_pwm_request),
  .primary_current_trip(primary_current_trip),
  .pwm_watchdog_reset(pwm_watchdog_reset), .desat_pwm_trip(desat_pwm_trip),
  .desat_irq_flag(desat_irq_flag),
  .primary_current_trip_blanked(primary_current_trip_blanked),
  .primary_gate_drive(primary_gate_drive), .secondary_gate_drive(secondary_gate_drive)
);

/* File: tb/tb_pwm_frontend_config_bank.sv */
`timescale 1ns/1ps
module tb_pwm_frontend_config_bank;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd_data, prdata;
  logic [3:0]  pstrb = 4'h0, current_offset_code;
  logic        watchdog_pulse = 1'b0, primary_pwm_request = 1'b0, secondary_pwm_request = 1'b0;
  logic        desat_level = 1'b0, trip_enable = 1'b0, rd_err, pready, pslverr;
  logic        desat_comparator_raw, primary_current_trip, desat_input_select, slope_bypass;
  logic        pwm_watchdog_reset, desat_pwm_trip, desat_irq_flag, primary_current_trip_blanked;
  logic        primary_gate_drive, secondary_gate_drive;
  logic [7:0]  ov_level_code, desat_offset_trim;
  logic [5:0]  slope_rate_code;
  logic [1:0]  blanking_code;
  int          err_total = 0, cmp_count = 0;
  // Stands in for the factory calibration word; the value is arbitrary.
  localparam logic [7:0] FACTORY_TRIM = 8'h5a;
  logic [11:0] adr [9] = '{pwm_frontend_pkg::ADDR_OV_LEVEL, pwm_frontend_pkg::ADDR_DESAT_CTRL,
    pwm_frontend_pkg::ADDR_CUR_OFFSET, pwm_frontend_pkg::ADDR_BLANKING,
    pwm_frontend_pkg::ADDR_SLOPE, pwm_frontend_pkg::ADDR_DEAD_TIME,
    pwm_frontend_pkg::ADDR_OFFSET_TRIM, pwm_frontend_pkg::ADDR_BYPASS, pwm_frontend_pkg::ADDR_FLAG};
  int          msk [8] = '{'hff, 'hff, 'h0f, 'h03, 'h7f, 'hff, 'hff, 'h03};
  int          leading_edge_blanking [4] = '{0, pwm_frontend_pkg::LEB_CYC_1, pwm_frontend_pkg::LEB_CYC_2,
    pwm_frontend_pkg::LEB_CYC_3};

  pwm_frontend_config_bank i_pwm_frontend_config_bank (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .desat_comparator_raw(desat_comparator_raw),
    .watchdog_pulse(watchdog_pulse), .primary_pwm_request(primary_pwm_request),
    .secondary_pwm_request(secondary_pwm_request),
    .primary_current_trip(primary_current_trip),
    .ov_level_code(ov_level_code), .desat_offset_trim(desat_offset_trim),
    .desat_input_select(desat_input_select), .pwm_watchdog_reset(pwm_watchdog_reset),
    .desat_pwm_trip(desat_pwm_trip), .desat_irq_flag(desat_irq_flag),
    .current_offset_code(current_offset_code), .blanking_code(blanking_code),
    .primary_current_trip_blanked(primary_current_trip_blanked),
    .slope_bypass(slope_bypass), .slope_rate_code(slope_rate_code),
    .primary_gate_drive(primary_gate_drive), .secondary_gate_drive(secondary_gate_drive)
  );
  power_stage_model i_power_stage_model (
    .desat_level(desat_level), .trip_enable(trip_enable),
    .primary_gate_drive(primary_gate_drive), .desat_comparator_raw(desat_comparator_raw),
    .primary_current_trip(primary_current_trip)
  );

  always #2.5 pclk = ~pclk;

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      err_total++;
      report_and_stop();
    end else begin
      rd_data = prdata;
      rd_err  = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d}, 4'hf);
  endtask

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0, 4'h0);
  endtask

  initial begin
    int v, p, r, f, k, kp, ks, np, ns;
    int e [8];
    void'($urandom(32'hbacd8cd8));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      rd(adr[i]);
      chk("reset value", 32'h0, rd_data);
    end
    for (int i = 0; i < 8; i++) begin
      v = (i == 6) ? FACTORY_TRIM : $urandom % 256;
      wr(adr[i], v[7:0]);
      e[i] = v & msk[i];
      if (i == 1) e[i] = (e[i] & 'hfb) | (((v >> 4) & 1) << 2);
      repeat (4) @(posedge pclk);
      rd(adr[i]);
      chk("readback", e[i], rd_data);
    end
    chk("ov pin", e[0], ov_level_code);
    chk("mux pin", e[1] >> 7, desat_input_select);
    chk("trim pin", FACTORY_TRIM, desat_offset_trim);
    chk("offset pin", e[2], current_offset_code);
    chk("blank pin", e[3], blanking_code);
    chk("slope pins", e[4], {slope_bypass, slope_rate_code});
    apb(1'b1, adr[0], ~e[0], 4'h0);
    rd(adr[0]);
    chk("strobe off", e[0], rd_data);
    rd(12'h7fc);
    chk("unmapped err", 1, rd_err);
    chk("unmapped data", 0, rd_data);
    for (int m = 0; m < 8; m++) begin
      p = (m >> 2) & 1;
      r = (m >> 1) & 1;
      f = m & 1;
      wr(pwm_frontend_pkg::ADDR_DESAT_CTRL, {3'h0, p[0], f[0], 1'b0, r[0], f[0]});
      repeat (5) @(posedge pclk);
      wr(pwm_frontend_pkg::ADDR_FLAG, 8'h01);
      @(posedge pclk);
      #1 chk("flag clear", 0, desat_irq_flag);
      desat_level <= 1'b1;
      repeat (5) @(posedge pclk);
      #1 chk("flag rise", p ? f : r, desat_irq_flag);
      chk("desat trip", (1 - p) & f, desat_pwm_trip);
      rd(pwm_frontend_pkg::ADDR_DESAT_CTRL);
      chk("status", 1 - p, rd_data[2]);
      desat_level <= 1'b0;
      repeat (5) @(posedge pclk);
      #1 chk("flag fall", r | f, desat_irq_flag);
    end
    for (int w = 0; w < 2; w++) begin
      wr(pwm_frontend_pkg::ADDR_DESAT_CTRL, {1'b0, w[0], 6'h00});
      @(posedge pclk);
      watchdog_pulse <= 1'b1;
      @(posedge pclk);
      watchdog_pulse <= 1'b0;
      #1 chk("watchdog", w, pwm_watchdog_reset);
    end
    wr(pwm_frontend_pkg::ADDR_BYPASS, 8'h00);
    for (int t = 0; t < 3; t++) begin
      v = (t == 0) ? 0 : (t == 1) ? 15 : $urandom % 16;
      wr(pwm_frontend_pkg::ADDR_DEAD_TIME, {v[3:0], 4'hf - v[3:0]});
      np = ((v + 1) * 16 + 4) / 5 + 1;
      ns = ((16 - v) * 16 + 4) / 5 + 1;
      @(posedge pclk);
      primary_pwm_request   <= 1'b1;
      secondary_pwm_request <= 1'b1;
      kp = 0;
      ks = 0;
      for (k = 1; k < 70; k++) begin
        @(posedge pclk);
        #1 if (kp == 0 && primary_gate_drive === 1'b1) kp = k;
        if (ks == 0 && secondary_gate_drive === 1'b1) ks = k;
      end
      chk("primary delay", np, kp);
      chk("secondary delay", ns, ks);
      @(posedge pclk);
      primary_pwm_request   <= 1'b0;
      secondary_pwm_request <= 1'b0;
      @(posedge pclk);
      #1 chk("drives off", 0, {primary_gate_drive, secondary_gate_drive});
    end
    wr(pwm_frontend_pkg::ADDR_BYPASS, 8'h03);
    trip_enable <= 1'b1;
    for (int b = 0; b < 4; b++) begin
      wr(pwm_frontend_pkg::ADDR_BLANKING, {6'h00, b[1:0]});
      @(posedge pclk);
      primary_pwm_request <= 1'b1;
      kp = 0;
      for (k = 0; k < 80 && primary_current_trip_blanked !== 1'b1; k++) begin
        @(posedge pclk);
        #1 if (primary_gate_drive === 1'b1) kp++;
      end
      chk("blank window", 1, kp >= leading_edge_blanking[b] && kp <= leading_edge_blanking[b] + 3);
      @(posedge pclk);
      primary_pwm_request <= 1'b0;
      @(posedge pclk);
    end
    report_and_stop();
  end
endmodule // tb_pwm_frontend_config_bank

/* File: verilog/pwm_frontend_config_bank.sv */
// How it works
// R01: Hold 8-bit overvoltage level code for DAC.
// R02: Input select bit picks bandgap or pin.
// R03: Watchdog resets PWM only when enabled.
// R04: Polarity bit inverts comparator output.
// R05: Output enable gates comparator into PWM.
// R06: Status bit shows polarity-adjusted comparator.
// R07: Enabled rising edge sets desat flag.
// R08: Enabled falling edge sets desat flag.
// R09: Flag sets regardless of output enable.
// R10: Firmware copies factory trim into trim register.
// R11: 4-bit current offset code, upper bits zero.
// R12: 2-bit blanking code, upper bits zero.
// R13: Ignore current sense during blanking after turn-on.
// R14: Slope bypass bit disables the ramp.
// R15: 6-bit slope rate code drives ramp.
// R16: Independent dead time, active when bypass clear.
// R17: Upper nibble sets primary turn-on delay.
// R18: Lower nibble sets secondary turn-on delay.
// R19: Two-flop synchroniser before edge detection.
// R20: Count 16 ns steps until code plus one; the code adds 5 ns per clock until (code + 1) * 16 ns.
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps

module dead_timer #(
  parameter int CODE_W = 4
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              request,
  input  wire logic              bypass,
  input  wire logic [CODE_W-1:0] code,
  output logic                   drive
);

  localparam int NS_W = pwm_frontend_pkg::DEAD_NS_W;
  localparam logic [NS_W-1:0] STEP_NS = NS_W'(pwm_frontend_pkg::CLK_PERIOD_NS);

  logic [NS_W-1:0] elapsed_r;
  logic [NS_W-1:0] target;
  logic            reached;

  // Turn-on waits for (code + 1) steps of 16 ns, measured in elapsed nanoseconds.
  assign target  = NS_W'((int'(code) + 1) * pwm_frontend_pkg::DEAD_STEP_NS); // [R17] [R18] [R20]
  assign reached = (elapsed_r >= target);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      elapsed_r <= '0;
      drive     <= 1'b0;
    end else if (!request) begin
      elapsed_r <= '0;
      drive     <= 1'b0;
    end else if (bypass) begin
      drive <= 1'b1; // [R16]
    end else begin
      if (!reached) begin
        elapsed_r <= elapsed_r + STEP_NS; // [R20]
      end
      drive <= reached; // [R16]
    end
  end

endmodule // dead_timer

module pwm_frontend_config_bank (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        desat_comparator_raw,
  input  wire logic        watchdog_pulse,
  input  wire logic        primary_pwm_request,
  input  wire logic        secondary_pwm_request,
  input  wire logic        primary_current_trip,
  output logic      [7:0]  ov_level_code,
  output logic      [7:0]  desat_offset_trim,
  output logic             desat_input_select,
  output logic             pwm_watchdog_reset,
  output logic             desat_pwm_trip,
  output logic             desat_irq_flag,
  output logic      [3:0]  current_offset_code,
  output logic      [1:0]  blanking_code,
  output logic             primary_current_trip_blanked,
  output logic             slope_bypass,
  output logic      [5:0]  slope_rate_code,
  output logic             primary_gate_drive,
  output logic             secondary_gate_drive
);

  localparam int DW  = pwm_frontend_pkg::DATA_W;
  localparam int LW  = pwm_frontend_pkg::LEB_CNT_W;
  localparam int DCW = pwm_frontend_pkg::DEAD_CODE_W;

  pwm_frontend_pkg::desat_ctrl_type desat_ctrl_r;

  logic [7:0]    ov_level_r;
  logic [7:0]    trim_r;
  logic [3:0]    cur_offset_r;
  logic [1:0]    blank_r;
  logic          slope_byp_r;
  logic [5:0]    slope_rate_r;
  logic [7:0]    dead_r;
  logic [1:0]    bypass_r;
  logic          cmp_meta_r;
  logic          cmp_sync_r;
  logic          cmp_adj_r;
  logic          flag_r;
  logic          prim_drive_d_r;
  logic [LW-1:0] blank_cnt_r;
  logic [DW-1:0] prdata_r;
  logic          pready_r;
  logic          pslverr_r;
  logic          prim_drive;
  logic          sec_drive;

  // APB decode: read data is captured in the setup cycle; writes take effect in the single access cycle.
  wire setup_phase = psel && !penable;
  wire wr_access   = psel && penable && pready_r && pwrite && pstrb[0];
  wire sel_ov      = (paddr == pwm_frontend_pkg::ADDR_OV_LEVEL);
  wire sel_desat   = (paddr == pwm_frontend_pkg::ADDR_DESAT_CTRL);
  wire sel_cur     = (paddr == pwm_frontend_pkg::ADDR_CUR_OFFSET);
  wire sel_blank   = (paddr == pwm_frontend_pkg::ADDR_BLANKING);
  wire sel_slope   = (paddr == pwm_frontend_pkg::ADDR_SLOPE);
  wire sel_dead    = (paddr == pwm_frontend_pkg::ADDR_DEAD_TIME);
  wire sel_trim    = (paddr == pwm_frontend_pkg::ADDR_OFFSET_TRIM);
  wire sel_byp     = (paddr == pwm_frontend_pkg::ADDR_BYPASS);
  wire sel_flag    = (paddr == pwm_frontend_pkg::ADDR_FLAG);
  wire mapped      = sel_ov || sel_desat || sel_cur || sel_blank || sel_slope ||
                     sel_dead || sel_trim || sel_byp || sel_flag;

  logic [DW-1:0] rd_mux;

  always_comb begin
    rd_mux = '0;
    if (sel_ov) begin
      rd_mux[7:0] = ov_level_r;
    end else if (sel_desat) begin
      rd_mux[7:0] = {desat_ctrl_r[7:3], cmp_adj_r, desat_ctrl_r[1:0]}; // [R06]
    end else if (sel_cur) begin
      rd_mux[pwm_frontend_pkg::CUR_OFFSET_W-1:0] = cur_offset_r; // [R11]
    end else if (sel_blank) begin
      rd_mux[pwm_frontend_pkg::BLANK_W-1:0] = blank_r; // [R12]
    end else if (sel_slope) begin
      rd_mux[pwm_frontend_pkg::SLOPE_BYP_BIT]        = slope_byp_r;
      rd_mux[pwm_frontend_pkg::SLOPE_RATE_W-1:0]     = slope_rate_r;
    end else if (sel_dead) begin
      rd_mux[7:0] = dead_r;
    end else if (sel_trim) begin
      rd_mux[7:0] = trim_r;
    end else if (sel_byp) begin
      rd_mux[1:0] = bypass_r;
    end else if (sel_flag) begin
      rd_mux[pwm_frontend_pkg::FLAG_BIT] = flag_r;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r  <= '0;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r  <= (setup_phase && !pwrite) ? rd_mux : '0;
      pready_r  <= setup_phase;
      pslverr_r <= setup_phase && !mapped;
    end
  end

  // Software configuration writes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ov_level_r   <= pwm_frontend_pkg::RST_OV_LEVEL;
      desat_ctrl_r <= pwm_frontend_pkg::RST_DESAT_CTRL;
      cur_offset_r <= pwm_frontend_pkg::RST_CUR_OFFSET[3:0];
      blank_r      <= pwm_frontend_pkg::RST_BLANKING[1:0];
      slope_byp_r  <= pwm_frontend_pkg::RST_SLOPE[pwm_frontend_pkg::SLOPE_BYP_BIT];
      slope_rate_r <= pwm_frontend_pkg::RST_SLOPE[5:0];
      dead_r       <= pwm_frontend_pkg::RST_DEAD_TIME;
      trim_r       <= pwm_frontend_pkg::RST_OFFSET_TRIM;
      bypass_r     <= pwm_frontend_pkg::RST_BYPASS[1:0];
    end else if (wr_access) begin
      if (sel_ov) begin
        ov_level_r <= pwdata[7:0]; // [R01]
      end
      if (sel_desat) begin
        desat_ctrl_r        <= pwdata[7:0];
        desat_ctrl_r.status <= 1'b0;
      end
      if (sel_cur) begin
        cur_offset_r <= pwdata[pwm_frontend_pkg::CUR_OFFSET_W-1:0]; // [R11]
      end
      if (sel_blank) begin
        blank_r <= pwdata[pwm_frontend_pkg::BLANK_W-1:0]; // [R12]
      end
      if (sel_slope) begin
        slope_byp_r  <= pwdata[pwm_frontend_pkg::SLOPE_BYP_BIT]; // [R14]
        slope_rate_r <= pwdata[pwm_frontend_pkg::SLOPE_RATE_W-1:0]; // [R15]
      end
      if (sel_dead) begin
        dead_r <= pwdata[7:0];
      end
      if (sel_trim) begin
        trim_r <= pwdata[7:0]; // [R10]
      end
      if (sel_byp) begin
        bypass_r <= pwdata[1:0];
      end
    end
  end

  // Comparator path: synchronise, then apply polarity before status and edges.
  wire cmp_adj  = cmp_sync_r ^ desat_ctrl_r.polarity_invert; // [R04]
  wire cmp_rise = cmp_adj && !cmp_adj_r;
  wire cmp_fall = !cmp_adj && cmp_adj_r;
  wire flag_set = (cmp_rise && desat_ctrl_r.rise_irq_enable) ||
                  (cmp_fall && desat_ctrl_r.fall_irq_enable); // [R07] [R08] [R09]
  wire flag_clr = wr_access && sel_flag && pwdata[pwm_frontend_pkg::FLAG_BIT];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmp_meta_r <= 1'b0;
      cmp_sync_r <= 1'b0;
      cmp_adj_r  <= 1'b0;
      flag_r     <= 1'b0;
    end else begin
      cmp_meta_r <= desat_comparator_raw; // [R19]
      cmp_sync_r <= cmp_meta_r; // [R19]
      cmp_adj_r  <= cmp_adj; // [R06]
      flag_r     <= flag_set || (flag_r && !flag_clr);
    end
  end

  // Leading-edge blanking after each primary turn-on.
  logic [LW-1:0] leb_cycles;

  always_comb begin
    case (blank_r)
      2'h1:    leb_cycles = LW'(pwm_frontend_pkg::LEB_CYC_1);
      2'h2:    leb_cycles = LW'(pwm_frontend_pkg::LEB_CYC_2);
      2'h3:    leb_cycles = LW'(pwm_frontend_pkg::LEB_CYC_3);
      default: leb_cycles = '0;
    endcase
  end

  wire prim_on_edge = prim_drive && !prim_drive_d_r;
  wire blanking     = prim_on_edge ? (leb_cycles != '0) : (blank_cnt_r != '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prim_drive_d_r <= 1'b0;
      blank_cnt_r    <= '0;
    end else begin
      prim_drive_d_r <= prim_drive;
      if (prim_on_edge) begin
        blank_cnt_r <= leb_cycles - LW'(1); // [R12] [R13]
      end else if (blank_cnt_r != '0) begin
        blank_cnt_r <= blank_cnt_r - LW'(1);
      end
    end
  end

  dead_timer #(
    .CODE_W (DCW)
  ) u_primary_dead (
    .pclk    (pclk),
    .presetn (presetn),
    .request (primary_pwm_request),
    .bypass  (bypass_r[pwm_frontend_pkg::BYP_P_BIT]),
    .code    (dead_r[pwm_frontend_pkg::DEAD_P_LSB +: DCW]),
    .drive   (prim_drive)
  );

  dead_timer #(
    .CODE_W (DCW)
  ) u_secondary_dead (
    .pclk    (pclk),
    .presetn (presetn),
    .request (secondary_pwm_request),
    .bypass  (bypass_r[pwm_frontend_pkg::BYP_S_BIT]),
    .code    (dead_r[pwm_frontend_pkg::DEAD_S_LSB +: DCW]),
    .drive   (sec_drive)
  );

  // Registered outputs toward the power stage and analog blocks.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwm_watchdog_reset           <= 1'b0;
      desat_pwm_trip               <= 1'b0;
      primary_current_trip_blanked <= 1'b0;
    end else begin
      pwm_watchdog_reset <= watchdog_pulse && desat_ctrl_r.watchdog_reset_enable; // [R03]
      desat_pwm_trip     <= cmp_adj && desat_ctrl_r.output_enable; // [R05]
      primary_current_trip_blanked <= primary_current_trip && !blanking; // [R13]
    end
  end

  assign prdata               = prdata_r;
  assign pready               = pready_r;
  assign pslverr              = pslverr_r;
  assign ov_level_code        = ov_level_r; // [R01]
  assign desat_offset_trim    = trim_r;
  assign desat_input_select   = desat_ctrl_r.input_select; // [R02]
  assign desat_irq_flag       = flag_r;
  assign current_offset_code  = cur_offset_r;
  assign blanking_code        = blank_r;
  assign slope_bypass         = slope_byp_r; // [R14]
  assign slope_rate_code      = slope_rate_r; // [R15]
  assign primary_gate_drive   = prim_drive;
  assign secondary_gate_drive = sec_drive;

endmodule // pwm_frontend_config_bank
